// file: shared/pmt8_pkg.sv
`default_nettype none
package pmt8_pkg;
  // ****************************************************************
  // register map (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [11:0] PMT8_OFF_COUNT = 12'h000;
  localparam logic [11:0] PMT8_OFF_PERIOD = 12'h004;
  localparam logic [11:0] PMT8_OFF_CTRL = 12'h008;
  localparam logic [11:0] PMT8_OFF_FLAG = 12'h00c;
  localparam logic [11:0] PMT8_OFF_FLAG_CLR = 12'h010;
  localparam logic [11:0] PMT8_OFF_IRQ_EN = 12'h014;
  // ****************************************************************
  // control fields
  // ****************************************************************
  localparam int PMT8_CTRL_PRE_LSB = 0;
  localparam int PMT8_CTRL_RUN_BIT = 2;
  localparam int PMT8_CTRL_POST_LSB = 3;
  localparam logic [7:0] PMT8_CTRL_WMASK = 8'h7f;
  localparam int PMT8_FLAG_MATCH_BIT = 1;
  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] PMT8_COUNT_RST = 8'h00;
  localparam logic [7:0] PMT8_PERIOD_RST = 8'hff;
  localparam logic [7:0] PMT8_CTRL_RST = 8'h00;
  // ****************************************************************
  // timing: instruction clock is the system clock divided by four
  // ****************************************************************
  localparam int PMT8_CLK_MHZ = 10;
  localparam int PMT8_INSTR_DIV = 4;
  localparam logic [1:0] PMT8_PRE_DIV1 = 2'b00;
  localparam logic [1:0] PMT8_PRE_DIV4 = 2'b01;
endpackage
`default_nettype wire

// file: src/pmt8_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
// instruction clock divider plus selectable 1/4/16 tick prescaler
module pmt8_prescaler
  import pmt8_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic clear_in,
  input wire logic run_in,
  input wire logic [1:0] sel_in,
  output logic tick_out
);
  logic [1:0] instr_q;
  logic [3:0] pre_q;
  logic instr_en;
  logic [3:0] pre_max;

  // prescale ratio: 00 gives 1, 01 gives 4, 1x gives 16
  always_comb
  begin
    if (sel_in == PMT8_PRE_DIV1)
      pre_max = 4'h0;
    else if (sel_in == PMT8_PRE_DIV4)
      pre_max = 4'h3;
    else
      pre_max = 4'hf;
  end

  assign instr_en = (instr_q == 2'(PMT8_INSTR_DIV - 1));

  // instruction-clock divider; free running so phase stays fixed
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      instr_q <= 2'h0;
    else
      instr_q <= instr_q + 2'h1;
  end

  // prescale count, cleared by count or control writes
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pre_q <= 4'h0;
      tick_out <= 1'b0;
    end
    else if (clear_in)
    begin
      pre_q <= 4'h0;
      tick_out <= 1'b0;
    end
    else
    begin
      tick_out <= 1'b0;
      if (run_in && instr_en)
      begin
        if (pre_q >= pre_max)
        begin
          pre_q <= 4'h0;
          tick_out <= 1'b1;
        end
        else
          pre_q <= pre_q + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// file: src/pmt8_timer.sv
// Behaviour
// [RULE1] the count rises from zero each tick and wraps to zero on the tick after it equals the period.
// [RULE2] reset loads the period register with all ones.
// [RULE3] ticks are the clock over four, then over 1, 4 or 16 by the prescale select field.
// [RULE4] matches pass a postscaler dividing by the 4-bit select field plus one.
// [RULE5] postscaler output sets a sticky match flag at bit 1 until software clears it.
// [RULE6] count writes, control writes and reset clear prescaler and postscaler counts.
// [RULE7] a control write leaves the count value alone.
// [RULE8] the count is read/write and reset clears it to zero.
// [RULE9] the run bit at bit 2 lets the counter advance or stops it.
// [RULE10] control bit 7 is not implemented and reads zero.
// [RULE11] the raw match pulse is given to the serial port for its shift clock.
// [RULE12] the raw match and count serve as the pwm time base.
// [RULE13] the period register is readable and writable at any time.
// [RULE14] each tick compares against the period register as it stands then.
`timescale 1ns/1ps
`default_nettype none
module pmt8_timer
  import pmt8_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic irq_out,
  output logic serial_match_out,
  output logic pwm_match_out,
  output logic [7:0] pwm_count_out
);
  // ****************************************************************
  // reset synchroniser
  // ****************************************************************
  logic rst_meta_q;
  logic rst_sync_q;

  // release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ****************************************************************
  // register bus decode
  // ****************************************************************
  logic [7:0] count_q;
  logic [7:0] period_q;
  logic [7:0] ctrl_q;
  logic flag_q;
  logic irq_en_q;
  logic [3:0] post_q;
  logic tick;
  logic match;
  logic acc;
  logic wr;
  logic wr_count;
  logic wr_period;
  logic wr_ctrl;
  logic wr_clr;
  logic wr_en;
  logic post_fire;
  logic mapped;

  // address compare, shared by the write decode and the read mux
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // writes act at the access edge; only byte lane 0 carries register bits
  assign acc = psel_in && penable_in;
  assign wr = acc && pwrite_in && pstrb_in[0];
  assign wr_count = wr && hit(paddr_in, PMT8_OFF_COUNT);
  assign wr_period = wr && hit(paddr_in, PMT8_OFF_PERIOD);
  assign wr_ctrl = wr && hit(paddr_in, PMT8_OFF_CTRL);
  assign wr_clr = wr && hit(paddr_in, PMT8_OFF_FLAG_CLR);
  assign wr_en = wr && hit(paddr_in, PMT8_OFF_IRQ_EN);
  // unmapped offsets answer with an error and change nothing
  assign mapped = hit(paddr_in, PMT8_OFF_COUNT) ||
    hit(paddr_in, PMT8_OFF_PERIOD) || hit(paddr_in, PMT8_OFF_CTRL) ||
    hit(paddr_in, PMT8_OFF_FLAG) || hit(paddr_in, PMT8_OFF_FLAG_CLR) ||
    hit(paddr_in, PMT8_OFF_IRQ_EN);

  // ****************************************************************
  // prescaler
  // ****************************************************************
  pmt8_prescaler u_pre (
    .clk_in(clk_in),
    .rst_b_in(rst_sync_q),
    .clear_in(wr_count || wr_ctrl), // RULE6
    .run_in(ctrl_q[PMT8_CTRL_RUN_BIT]), // RULE9
    .sel_in(ctrl_q[PMT8_CTRL_PRE_LSB +: 2]), // RULE3
    .tick_out(tick)
  );

  // live period compare, so a new period counts at once
  assign match = tick && (count_q == period_q); // RULE14

  // ****************************************************************
  // registers
  // ****************************************************************
  // count: software write wins over a tick in the same cycle
  always_ff @(posedge clk_in or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      count_q <= PMT8_COUNT_RST; // RULE8
    else if (wr_count)
      count_q <= pwdata_in[7:0]; // RULE8
    else if (match)
      count_q <= 8'h00; // RULE1
    else if (tick)
      count_q <= count_q + 8'h01; // RULE1
  end

  // period register, writable at any time
  always_ff @(posedge clk_in or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      period_q <= PMT8_PERIOD_RST; // RULE2
    else if (wr_period)
      period_q <= pwdata_in[7:0]; // RULE13
  end

  // control; bit 7 masked so it always reads zero
  always_ff @(posedge clk_in or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      ctrl_q <= PMT8_CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= pwdata_in[7:0] & PMT8_CTRL_WMASK; // RULE10 RULE7
  end

  // postscaler: fires on match number select+1
  always_ff @(posedge clk_in or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      post_q <= 4'h0;
    else if (wr_count || wr_ctrl)
      post_q <= 4'h0; // RULE6
    else if (match)
    begin
      if (post_q >= ctrl_q[PMT8_CTRL_POST_LSB +: 4])
        post_q <= 4'h0; // RULE4
      else
        post_q <= post_q + 4'h1;
    end
  end

  // compare with >= so a lowered select cannot strand the count
  assign post_fire = match &&
    (post_q >= ctrl_q[PMT8_CTRL_POST_LSB +: 4]); // RULE4

  // sticky flag: a set in the clearing cycle wins
  always_ff @(posedge clk_in or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      flag_q <= 1'b0;
    else if (post_fire)
      flag_q <= 1'b1; // RULE5
    else if (wr_clr && pwdata_in[PMT8_FLAG_MATCH_BIT])
      flag_q <= 1'b0;
  end

  // interrupt enable
  always_ff @(posedge clk_in or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
      irq_en_q <= 1'b0;
    else if (wr_en)
      irq_en_q <= pwdata_in[PMT8_FLAG_MATCH_BIT];
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // registered outputs; interrupt follows the flag one cycle later
  always_ff @(posedge clk_in or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      irq_out <= 1'b0;
      serial_match_out <= 1'b0;
      pwm_match_out <= 1'b0;
      pwm_count_out <= 8'h00;
    end
    else
    begin
      irq_out <= flag_q && irq_en_q;
      serial_match_out <= match; // RULE11
      pwm_match_out <= match; // RULE12
      pwm_count_out <= count_q; // RULE12
    end
  end

  // apb answer: ready in the first access cycle, so no wait state
  always_ff @(posedge clk_in or negedge rst_sync_q)
  begin
    if (!rst_sync_q)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
    end
    else
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      if (psel_in && !penable_in)
      begin
        pready_out <= 1'b1;
        pslverr_out <= !mapped;
        prdata_out <= 32'h0000_0000;
        if (!pwrite_in)
        begin
          if (hit(paddr_in, PMT8_OFF_COUNT))
            prdata_out[7:0] <= count_q;
          else if (hit(paddr_in, PMT8_OFF_PERIOD))
            prdata_out[7:0] <= period_q;
          else if (hit(paddr_in, PMT8_OFF_CTRL))
            prdata_out[7:0] <= ctrl_q; // RULE10
          else if (hit(paddr_in, PMT8_OFF_FLAG))
            prdata_out[PMT8_FLAG_MATCH_BIT] <= flag_q;
          else if (hit(paddr_in, PMT8_OFF_IRQ_EN))
            prdata_out[PMT8_FLAG_MATCH_BIT] <= irq_en_q;
        end
      end
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_WRAP: assert property ( // RULE1
    @(posedge clk_in) disable iff (!rst_sync_q)
    (match && !wr_count) |=> count_q == 8'h00)
    else $error("count did not wrap after match");
  AST_INC: assert property ( // RULE1
    @(posedge clk_in) disable iff (!rst_sync_q)
    (tick && !match && !wr_count) |=> count_q == $past(count_q) + 8'h01)
    else $error("count did not advance");
  AST_PERIOD_RST: assert property ( // RULE2
    @(posedge clk_in) $rose(rst_sync_q) |-> period_q == 8'hff)
    else $error("period not all ones after reset");
  AST_TICK_SPACE: assert property ( // RULE3
    @(posedge clk_in) disable iff (!rst_sync_q)
    tick |=> !tick [*3])
    else $error("ticks closer than four clocks");
  AST_FLAG_SET: assert property ( // RULE5
    @(posedge clk_in) disable iff (!rst_sync_q)
    post_fire |=> flag_q)
    else $error("match flag not set");
  AST_POST_CLR: assert property ( // RULE6
    @(posedge clk_in) disable iff (!rst_sync_q)
    (wr_count || wr_ctrl) |=> post_q == 4'h0)
    else $error("postscaler not cleared by write");
  AST_CTRL_KEEP: assert property ( // RULE7
    @(posedge clk_in) disable iff (!rst_sync_q)
    (wr_ctrl && !tick) |=> count_q == $past(count_q))
    else $error("control write changed count");
  AST_STOP: assert property ( // RULE9
    @(posedge clk_in) disable iff (!rst_sync_q)
    (!ctrl_q[PMT8_CTRL_RUN_BIT] && !wr_count && !wr_ctrl) [*2]
    |=> count_q == $past(count_q))
    else $error("stopped counter moved");
  AST_BIT7: assert property ( // RULE10
    @(posedge clk_in) disable iff (!rst_sync_q)
    ctrl_q[7] == 1'b0)
    else $error("control bit 7 set");
  AST_SERIAL: assert property ( // RULE11 RULE12
    @(posedge clk_in) disable iff (!rst_sync_q)
    match |=> serial_match_out && pwm_match_out)
    else $error("raw match not forwarded");

  // ****************************************************************
  // register and output assertions
  // ****************************************************************
  AST_COUNT_WR: assert property ( // RULE8
    @(posedge clk_in) disable iff (!rst_sync_q)
    wr_count |=> count_q == $past(pwdata_in[7:0]))
    else $error("count write did not land");
  AST_PERIOD_WR: assert property ( // RULE13
    @(posedge clk_in) disable iff (!rst_sync_q)
    wr_period |=> period_q == $past(pwdata_in[7:0]))
    else $error("period write did not land");
  AST_CTRL_WR: assert property ( // RULE9
    @(posedge clk_in) disable iff (!rst_sync_q)
    wr_ctrl |=> ctrl_q[6:0] == $past(pwdata_in[6:0]))
    else $error("control write did not land");
  AST_PRE_CLR: assert property ( // RULE6
    @(posedge clk_in) disable iff (!rst_sync_q)
    (wr_count || wr_ctrl) |=> !tick)
    else $error("prescaler ticked right after a clearing write");
  AST_POST_HOLD: assert property ( // RULE4
    @(posedge clk_in) disable iff (!rst_sync_q)
    (!match && !wr_count && !wr_ctrl) |=> post_q == $past(post_q))
    else $error("postscaler moved without a match");
  AST_TICK_STOP: assert property ( // RULE9
    @(posedge clk_in) disable iff (!rst_sync_q)
    !ctrl_q[PMT8_CTRL_RUN_BIT] |=> !tick)
    else $error("tick while the timer is off");
  AST_IDLE: assert property ( // RULE1
    @(posedge clk_in) disable iff (!rst_sync_q)
    (!tick && !wr_count) |=> count_q == $past(count_q))
    else $error("count moved without a tick");
  AST_FLAG_HOLD: assert property ( // RULE5
    @(posedge clk_in) disable iff (!rst_sync_q)
    (flag_q && !wr_clr) |=> flag_q)
    else $error("match flag dropped without a clear");
  AST_FLAG_QUIET: assert property ( // RULE5
    @(posedge clk_in) disable iff (!rst_sync_q)
    (!flag_q && !post_fire) |=> !flag_q)
    else $error("match flag rose without a postscaler fire");
  AST_IRQ_SET: assert property ( // RULE5
    @(posedge clk_in) disable iff (!rst_sync_q)
    (flag_q && irq_en_q) |=> irq_out)
    else $error("interrupt missing for enabled flag");
  AST_IRQ_CLR: assert property ( // RULE5
    @(posedge clk_in) disable iff (!rst_sync_q)
    !(flag_q && irq_en_q) |=> !irq_out)
    else $error("interrupt without enabled flag");
  AST_MATCH_ONE: assert property ( // RULE11
    @(posedge clk_in) disable iff (!rst_sync_q)
    serial_match_out |=> !serial_match_out)
    else $error("raw match pulse longer than one cycle");
  AST_PWM_COUNT: assert property ( // RULE12
    @(posedge clk_in) disable iff (!rst_sync_q)
    1'b1 |=> pwm_count_out == $past(count_q))
    else $error("pwm count copy out of step");
endmodule
`default_nettype wire

// file: bench/period_match_timer8_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module period_match_timer8_tb_top;
  import pmt8_pkg::*;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, smatch, pmatch, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [7:0] pcount;
  logic [15:0] rnd_q = 16'hd663;
  int miscompares = 0;
  int compares = 0;
  int n, s, per, pre;

  pmt8_timer DUT (.clk_in(clk), .rst_b_in(rst_b), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq),
    .serial_match_out(smatch), .pwm_match_out(pmatch),
    .pwm_count_out(pcount));

  // 10 MHz system clock
  always #50 clk = ~clk;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; the wait is bounded so a dead slave cannot hang us
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
      chk(32'h0, 32'h1);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // cycles from one raw match pulse to the next; a model of the count
  // predicts every step of the pwm copy from the period alone
  task automatic gap(output int g);
    int last;
    last = pcount;
    g = 0;
    do
    begin
      @(negedge clk);
      g++;
      chk(pmatch, smatch);
      if (pcount !== last[7:0])
      begin
        chk(pcount, (last == per) ? 0 : last + 1);
        last = pcount;
      end
      if (smatch === 1'b1)
        chk(pcount, per);
    end
    while (smatch !== 1'b1 && g < 3000);
  endtask

  task automatic report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog: whole run is well under 20000 cycles
  initial
  begin
    #(100 * 60000);
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(PMT8_OFF_COUNT, 32'h0);
    rdchk(PMT8_OFF_PERIOD, 32'hff);
    rdchk(PMT8_OFF_CTRL, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk(err, 1'b1);
    $display("test reset values done");
    // random control and period values; bit 7 must read zero
    for (int i = 0; i < 4; i++)
    begin
      rnd_q = lfsr_next(rnd_q);
      apb(1'b1, PMT8_OFF_CTRL, {24'h0, rnd_q[7:0]});
      rdchk(PMT8_OFF_CTRL, {24'h0, rnd_q[7:0] & 8'h7f});
      apb(1'b1, PMT8_OFF_PERIOD, {24'h0, rnd_q[15:8]});
      rdchk(PMT8_OFF_PERIOD, {24'h0, rnd_q[15:8]});
    end
    pstrb <= 4'he;
    apb(1'b1, PMT8_OFF_PERIOD, 32'h0);
    pstrb <= 4'hf;
    rdchk(PMT8_OFF_PERIOD, {24'h0, rnd_q[15:8]});
    $display("test register access done");
    // stopped timer holds its count, control write keeps it
    apb(1'b1, PMT8_OFF_CTRL, 32'h0);
    apb(1'b1, PMT8_OFF_COUNT, 32'h37);
    repeat (40) @(posedge clk);
    rdchk(PMT8_OFF_COUNT, 32'h37);
    apb(1'b1, PMT8_OFF_CTRL, 32'h78);
    rdchk(PMT8_OFF_COUNT, 32'h37);
    chk(pcount, 8'h37);
    $display("test hold done");
    // match spacing for every prescale code
    for (int sel = 0; sel < 4; sel++)
    begin
      rnd_q = lfsr_next(rnd_q);
      per = rnd_q[2:0];
      pre = (sel == 0) ? 1 : (sel == 1) ? 4 : 16;
      apb(1'b1, PMT8_OFF_CTRL, 32'h0);
      apb(1'b1, PMT8_OFF_COUNT, 32'h0);
      apb(1'b1, PMT8_OFF_PERIOD, per);
      apb(1'b1, PMT8_OFF_CTRL, 32'h4 | sel);
      gap(n);
      gap(n);
      chk(n, 4 * pre * (per + 1));
    end
    $display("test prescale done");
    // postscaler ratio and sticky flag with interrupt
    apb(1'b1, PMT8_OFF_IRQ_EN, 32'h2);
    rnd_q = lfsr_next(rnd_q);
    for (int j = 0; j < 3; j++)
    begin
      s = (j == 0) ? 0 : (j == 1) ? 15 : rnd_q[3:0];
      apb(1'b1, PMT8_OFF_CTRL, 32'h0);
      apb(1'b1, PMT8_OFF_COUNT, 32'h0);
      apb(1'b1, PMT8_OFF_PERIOD, 32'h1);
      apb(1'b1, PMT8_OFF_FLAG_CLR, 32'h2);
      rdchk(PMT8_OFF_FLAG, 32'h0);
      chk(irq, 1'b0);
      apb(1'b1, PMT8_OFF_CTRL, 32'h4 | (s << 3));
      n = 0;
      for (int k = 0; k < 400 && irq !== 1'b1; k++)
      begin
        @(negedge clk);
        if (smatch === 1'b1)
          n++;
      end
      chk(n, s + 1);
      rdchk(PMT8_OFF_FLAG, 32'h2);
    end
    apb(1'b1, PMT8_OFF_CTRL, 32'h0);
    repeat (20) @(posedge clk);
    rdchk(PMT8_OFF_FLAG, 32'h2);
    apb(1'b1, PMT8_OFF_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b1, PMT8_OFF_FLAG_CLR, 32'h2);
    rdchk(PMT8_OFF_FLAG, 32'h0);
    $display("test postscale done");
    // mid-run reset returns count, period, control and flag to reset
    apb(1'b1, PMT8_OFF_PERIOD, 32'h5a);
    apb(1'b1, PMT8_OFF_COUNT, 32'h21);
    apb(1'b1, PMT8_OFF_CTRL, 32'h4);
    repeat (10) @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rdchk(PMT8_OFF_COUNT, 32'h0);
    rdchk(PMT8_OFF_PERIOD, 32'hff);
    rdchk(PMT8_OFF_CTRL, 32'h0);
    rdchk(PMT8_OFF_FLAG, 32'h0);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
